//--- core/uhd_pkg.sv
// Purpose: Constants for the root hub and done queue block
// Assumes: 20 MHz clock, registers on a plain strobe port
// Notes:   Byte offsets, field positions and counts live here
// Operation
// - Hub or port change flag becoming set raises the hub change interrupt
// - Writing one to ownership request raises the ownership interrupt
// - Every retired descriptor is linked onto the done queue
// - At frame end with defer count zero, write done pointer, raise interrupt
// - Newest retired descriptor at queue head, oldest at tail
// - Two ports: first port register is port 0, second is port 1
// - One power control acts on both ports together
// - Over-current reported once for all ports
// - Descriptor registers read-only: simple hub, removable devices, 2 ms
// - Hub bit 0 write one powers off, bit 16 write one powers on
// - Hub bit 15 write one enables wakeup, bit 31 disables it
// - With wakeup enabled a connect change is a wakeup event
// - Hub bit 0 shows over-current, bit 17 flags its changes
// - Port low half shows status, high half flags status changes
// - Port bit 0 write one disables, bit 1 write one enables
// - Port bit 2 write one suspends, bit 3 write one resumes
// - Port bit 4 write one starts bus reset, reads one meanwhile
// - Port read: connect bit 0, enabled bit 1, suspended bit 2
// - Port read: power bit 8, low-speed device bit 9
// - Port change flags set on status change, write one clears
// - Done pointer not written again until write-back flag cleared
// - Pointer low bit set when an unmasked interrupt status is pending
package uhd_pkg;
	localparam logic [7:0] OFF_HUB    = 8'h00;
	localparam logic [7:0] OFF_PORT0  = 8'h04;
	localparam logic [7:0] OFF_PORT1  = 8'h08;
	localparam logic [7:0] OFF_DESC_A = 8'h0C;
	localparam logic [7:0] OFF_DESC_B = 8'h10;
	localparam logic [7:0] OFF_CMD    = 8'h14;
	localparam logic [7:0] OFF_INT_ST = 8'h18;
	localparam logic [7:0] OFF_INT_EN = 8'h1C;
	localparam logic [7:0] OFF_DONE   = 8'h20;
	localparam int HUB_PWR_OFF  = 0;
	localparam int HUB_WAKE_SET = 15;
	localparam int HUB_PWR_ON   = 16;
	localparam int HUB_OC_CHG   = 17;
	localparam int HUB_WAKE_CLR = 31;
	localparam int PRT_CONN     = 0;
	localparam int PRT_EN       = 1;
	localparam int PRT_SUSP     = 2;
	localparam int PRT_RESUME   = 3;
	localparam int PRT_RST      = 4;
	localparam int PRT_CONN_CHG = 16;
	localparam int PRT_EN_CHG   = 17;
	localparam int PRT_SUSP_CHG = 18;
	localparam int PRT_RST_CHG  = 20;
	localparam int CMD_OWN_REQ  = 3;
	localparam int INT_WD       = 1;
	localparam int INT_RHSC     = 6;
	localparam int INT_OC       = 30;
	localparam logic [31:0] DESC_A_VAL = 32'h01000002;
	localparam logic [31:0] DESC_B_VAL = 32'h00000000;
	localparam logic [2:0] DEFER_IDLE = 3'h7;
	localparam longint CLK_HZ    = 20000000;
	localparam longint FRAME_US  = 1000;
	localparam longint PRST_US   = 10000;
	localparam int FRAME_CYC = int'(FRAME_US * CLK_HZ / 1000000);
	localparam int PRST_CYC  = int'(PRST_US * CLK_HZ / 1000000);
endpackage

//--- core/uhd_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are static long compared with the clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module uhd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;
	// Two flip-flops per bit
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule // uhd_sync
`default_nettype wire

//--- core/uhd_port.sv
// Purpose: One downstream port of the root hub
// Assumes: Connect and speed inputs already synchronised
// Notes:   Status word laid out as the port register reads
`timescale 1ns/1ps
`default_nettype none
module uhd_port #(
	parameter int RST_CYC = uhd_pkg::PRST_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        connect_in,
	input  wire logic        low_speed_in,
	input  wire logic        power_in,
	input  wire logic        wr_in,
	input  wire logic [31:0] wdata_in,
	output logic      [31:0] status_out,
	output logic             change_out,
	output logic             conn_edge_out
);
	typedef struct packed {
		logic conn; logic en; logic susp; logic rst;
		logic conn_chg; logic en_chg; logic susp_chg; logic rst_chg;
		logic [17:0] cnt;
	} uhd_port_s;
	uhd_port_s s;
	uhd_port_s next_s;
	logic [31:0] w;
	logic [31:0] clr;
	// Port state, commands and change flags
	always_comb begin
		next_s = s;
		w = wr_in ? wdata_in : 32'h00000000;
		clr = w;
		next_s.conn = connect_in & power_in;
		if (!next_s.conn) begin
			next_s.en   = 1'b0;
			next_s.susp = 1'b0;
			next_s.rst  = 1'b0;
		end else if (s.rst) begin
			if (s.cnt == 18'h00000) begin
				next_s.rst = 1'b0;
				next_s.en  = 1'b1;
			end else begin
				next_s.cnt = s.cnt - 18'h00001;
			end
		end else begin
			if (w[uhd_pkg::PRT_CONN]) next_s.en = 1'b0;
			if (w[uhd_pkg::PRT_EN]) next_s.en = 1'b1;
			if (w[uhd_pkg::PRT_SUSP] && s.en) next_s.susp = 1'b1;
			if (w[uhd_pkg::PRT_RESUME]) next_s.susp = 1'b0;
			if (w[uhd_pkg::PRT_RST]) begin
				next_s.rst  = 1'b1;
				next_s.susp = 1'b0;
				next_s.cnt  = 18'(RST_CYC - 1);
			end
		end
		if (!next_s.en) next_s.susp = 1'b0;
		// Set wins over a clear in the same cycle
		next_s.conn_chg = (s.conn_chg & ~clr[uhd_pkg::PRT_CONN_CHG]) | (next_s.conn ^ s.conn);
		next_s.en_chg   = (s.en_chg & ~clr[uhd_pkg::PRT_EN_CHG]) | (next_s.en ^ s.en);
		next_s.susp_chg = (s.susp_chg & ~clr[uhd_pkg::PRT_SUSP_CHG]) | (next_s.susp ^ s.susp);
		next_s.rst_chg  = (s.rst_chg & ~clr[uhd_pkg::PRT_RST_CHG]) | (s.rst & ~next_s.rst);
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) s <= '0;
		else s <= next_s;
	end
	// Register view: status low, changes high
	assign status_out = {11'h000, s.rst_chg, 1'b0, s.susp_chg, s.en_chg, s.conn_chg, 6'h00,
		low_speed_in & s.conn, power_in, 3'h0, s.rst, 1'b0, s.susp, s.en, s.conn};
	assign change_out    = s.conn_chg | s.en_chg | s.susp_chg | s.rst_chg;
	assign conn_edge_out = next_s.conn ^ s.conn;
endmodule // uhd_port
`default_nettype wire

//--- core/uhd_root_hub.sv
// Purpose: Root hub registers and frame-end done queue write-back
// Assumes: Pins are asynchronous; schedule logic shares the clock
// Notes:   Shared-area writes leave as one-cycle strobes
//          Memory side must take every strobe
//          Lengths are parameters for short runs
`timescale 1ns/1ps
`default_nettype none
module uhd_root_hub #(
	parameter int FRAME_CYC = uhd_pkg::FRAME_CYC,
	parameter int PRST_CYC  = uhd_pkg::PRST_CYC
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,

	// Register port
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,

	// Pins from the two ports
	input  wire logic [1:0]  connect_in,
	input  wire logic [1:0]  low_speed_in,
	input  wire logic        overcurrent_in,

	// Descriptor retirement from the schedule
	input  wire logic        td_retire_in,
	input  wire logic [27:0] td_addr_in,
	input  wire logic [2:0]  td_delay_in,

	// Memory write strobes
	output logic             link_wr_out,
	output logic      [31:0] link_addr_out,
	output logic      [31:0] link_data_out,
	output logic             done_wr_out,
	output logic      [31:0] done_data_out,

	// Port drive and events
	output logic             port_power_out,
	output logic      [1:0]  port_enable_out,
	output logic      [1:0]  port_suspend_out,
	output logic      [1:0]  port_reset_out,
	output logic             wake_out,
	output logic             irq_out
);
	// Whole block state in one packed record: the next
	// copy is built combinationally and registered once,
	// so every top output leaves straight from a flip-flop
	typedef struct packed {
		// Register port and interrupts
		logic [31:0] rdata;
		logic [2:0]  int_sts;
		logic [2:0]  int_en;
		// Hub state
		logic        wake_en;
		logic        power;
		logic        oc_flag;
		logic        oc_chg;
		logic [8:0]  chg_any;
		// Done queue
		logic [27:0] head;
		logic [2:0]  defer;
		logic [17:0] frame;
		// Memory strobes
		logic        link_wr;
		logic [31:0] link_addr;
		logic [31:0] link_data;
		logic        done_wr;
		logic [31:0] done_data;
		// Port drive and events
		logic        wake;
		logic        irq;
		logic [1:0]  en;
		logic [1:0]  susp;
		logic [1:0]  rst;
	} uhd_top_s;

	// Interrupt status slots
	// Slot order inside int_sts and int_en
	localparam int S_WD = 0;
	localparam int S_RH = 1;
	localparam int S_OC = 2;

	uhd_top_s    s;
	uhd_top_s    next_s;

	// Pins after the synchronisers
	logic [1:0]  conn_sync;
	logic [1:0]  ls_sync;
	logic        oc_sync;

	// Port views and register write decode
	logic [31:0] port_sts [2];
	logic [1:0]  port_edge;
	logic [1:0]  port_wr;
	logic        hub_wr;

	// Next-state helpers
	logic [31:0] hw;
	logic [2:0]  isc;
	logic [2:0]  iset;
	logic [8:0]  chg_vec;
	logic        frame_end;
	logic        write_back;
	logic [27:0] head_base;
	logic [2:0]  defer_f;

	// Read views
	logic [31:0] hub_rd;
	logic [31:0] ist_rd;
	logic [31:0] ien_rd;

	// Pin synchronisers
	// Logic reads only the second stage
	uhd_sync #(.W(2)) u_conn_sync (
		.clk_in  (clk_in),
		.rst_b_in(rst_b_in),
		.d_in    (connect_in),
		.q_out   (conn_sync)
	);

	uhd_sync #(.W(2)) u_ls_sync (
		.clk_in  (clk_in),
		.rst_b_in(rst_b_in),
		.d_in    (low_speed_in),
		.q_out   (ls_sync)
	);

	uhd_sync #(.W(1)) u_oc_sync (
		.clk_in  (clk_in),
		.rst_b_in(rst_b_in),
		.d_in    (overcurrent_in),
		.q_out   (oc_sync)
	);

	// Write decode per port register
	// Exact byte match, other offsets ignored
	assign port_wr[0] = wr_in && (addr_in == uhd_pkg::OFF_PORT0);
	assign port_wr[1] = wr_in && (addr_in == uhd_pkg::OFF_PORT1);
	assign hub_wr     = wr_in && (addr_in == uhd_pkg::OFF_HUB);

	// Two downstream ports sharing one power control
	// Power-off drops both connect states at once
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_port
			// Each port gets its own write strobe
			uhd_port #(.RST_CYC(PRST_CYC)) u_port (
				.clk_in       (clk_in),
				.rst_b_in     (rst_b_in),
				.connect_in   (conn_sync[gi]),
				.low_speed_in (ls_sync[gi]),
				.power_in     (s.power),
				.wr_in        (port_wr[gi]),
				.wdata_in     (wdata_in),
				.status_out   (port_sts[gi]),
				.change_out   (),
				.conn_edge_out(port_edge[gi])
			);
		end
	endgenerate

	// Read views of the hub and interrupt registers
	// Unlisted bits read as zero
	always_comb begin
		hub_rd = 32'h00000000;
		hub_rd[0] = s.oc_flag;
		hub_rd[uhd_pkg::HUB_WAKE_SET] = s.wake_en;
		hub_rd[uhd_pkg::HUB_OC_CHG] = s.oc_chg;

		// Interrupt status and enable views
		ist_rd = 32'h00000000;
		ist_rd[uhd_pkg::INT_WD]   = s.int_sts[S_WD];
		ist_rd[uhd_pkg::INT_RHSC] = s.int_sts[S_RH];
		ist_rd[uhd_pkg::INT_OC]   = s.int_sts[S_OC];

		ien_rd = 32'h00000000;
		ien_rd[uhd_pkg::INT_WD]   = s.int_en[S_WD];
		ien_rd[uhd_pkg::INT_RHSC] = s.int_en[S_RH];
		ien_rd[uhd_pkg::INT_OC]   = s.int_en[S_OC];
	end

	// Next state of the whole block
	always_comb begin
		next_s = s;
		hw = hub_wr ? wdata_in : 32'h00000000;
		isc = 3'h0;
		iset = 3'h0;
		// Strobes drop unless raised below
		next_s.link_wr = 1'b0;
		next_s.done_wr = 1'b0;
		next_s.wake = 1'b0;

		// Register reads, data one cycle later
		// Zero outside the read cycle
		next_s.rdata = 32'h00000000;
		// Descriptor values are constants
		if (rd_in) begin
			case (addr_in)
				uhd_pkg::OFF_HUB:    next_s.rdata = hub_rd;
				uhd_pkg::OFF_PORT0:  next_s.rdata = port_sts[0];
				uhd_pkg::OFF_PORT1:  next_s.rdata = port_sts[1];
				uhd_pkg::OFF_DESC_A: next_s.rdata = uhd_pkg::DESC_A_VAL;
				uhd_pkg::OFF_DESC_B: next_s.rdata = uhd_pkg::DESC_B_VAL;
				uhd_pkg::OFF_INT_ST: next_s.rdata = ist_rd;
				uhd_pkg::OFF_INT_EN: next_s.rdata = ien_rd;
				uhd_pkg::OFF_DONE:   next_s.rdata = {s.head, 4'h0};
				default:             next_s.rdata = 32'h00000000;
			endcase
		end

		// Global power and wakeup enable commands
		// Power on wins over off in one write; wakeup off wins over on
		if (hw[uhd_pkg::HUB_PWR_OFF]) next_s.power = 1'b0;
		if (hw[uhd_pkg::HUB_PWR_ON]) next_s.power = 1'b1;
		if (hw[uhd_pkg::HUB_WAKE_SET]) next_s.wake_en = 1'b1;
		if (hw[uhd_pkg::HUB_WAKE_CLR]) next_s.wake_en = 1'b0;

		// Collective over-current and its change flag
		// Pulses under one clock may be missed
		next_s.oc_flag = oc_sync;
		next_s.oc_chg = (s.oc_chg & ~hw[uhd_pkg::HUB_OC_CHG]) | (oc_sync ^ s.oc_flag);

		// Connect change seen as wakeup while enabled
		// One cycle per connect edge
		next_s.wake = s.wake_en & (|port_edge);

		// Hub change interrupt on a flag becoming set
		// Each flag has its own previous copy, so one that
		// rises while another is pending is not lost
		chg_vec[8] = s.oc_chg;
		for (int p = 0; p < 2; p++) begin
			chg_vec[4*p]   = port_sts[p][uhd_pkg::PRT_CONN_CHG];
			chg_vec[4*p+1] = port_sts[p][uhd_pkg::PRT_EN_CHG];
			chg_vec[4*p+2] = port_sts[p][uhd_pkg::PRT_SUSP_CHG];
			chg_vec[4*p+3] = port_sts[p][uhd_pkg::PRT_RST_CHG];
		end
		next_s.chg_any = chg_vec;
		iset[S_RH] = |(chg_vec & ~s.chg_any);

		// Ownership request raises its interrupt
		// A zero in the command bit changes nothing
		if (wr_in && (addr_in == uhd_pkg::OFF_CMD)) begin
			iset[S_OC] = wdata_in[uhd_pkg::CMD_OWN_REQ];
		end

		// Interrupt status clear and enable writes
		// Status is write-one-to-clear
		if (wr_in && (addr_in == uhd_pkg::OFF_INT_ST)) begin
			isc[S_WD] = wdata_in[uhd_pkg::INT_WD];
			isc[S_RH] = wdata_in[uhd_pkg::INT_RHSC];
			isc[S_OC] = wdata_in[uhd_pkg::INT_OC];
		end

		if (wr_in && (addr_in == uhd_pkg::OFF_INT_EN)) begin
			next_s.int_en[S_WD] = wdata_in[uhd_pkg::INT_WD];
			next_s.int_en[S_RH] = wdata_in[uhd_pkg::INT_RHSC];
			next_s.int_en[S_OC] = wdata_in[uhd_pkg::INT_OC];
		end

		// Frame timer, one frame end per millisecond
		// Zero count marks the frame end
		frame_end = (s.frame == 18'h00000);
		if (frame_end) begin
			next_s.frame = 18'(FRAME_CYC - 1);
		end else begin
			next_s.frame = s.frame - 18'h00001;
		end

		// Write-back only once the previous one is cleared
		// Empty queue is not written back
		// Defer 7 means no delay pending
		write_back = frame_end && (s.defer == 3'h0) && !s.int_sts[S_WD];
		write_back = write_back && (s.head != 28'h0000000);
		// Count down only at frame ends
		defer_f = s.defer;
		if (write_back) begin
			next_s.done_wr   = 1'b1;
			next_s.done_data = {s.head, 3'h0, |(s.int_sts & s.int_en)};
			iset[S_WD]       = 1'b1;
			defer_f          = uhd_pkg::DEFER_IDLE;
		end else if (frame_end && (s.defer != 3'h0) && (s.defer != uhd_pkg::DEFER_IDLE)) begin
			defer_f = s.defer - 3'h1;
		end
		next_s.defer = defer_f;

		// Retired descriptor pushed at the queue head
		// Retire in a write-back cycle starts a new queue
		// Old head is the link; zero ends the queue
		head_base = write_back ? 28'h0000000 : s.head;
		next_s.head = head_base;
		if (td_retire_in) begin
			next_s.link_wr   = 1'b1;
			next_s.link_addr = {td_addr_in, 4'h0};
			next_s.link_data = {head_base, 4'h0};
			next_s.head      = td_addr_in;
			if (td_delay_in < defer_f) next_s.defer = td_delay_in;
		end

		// Set wins over a clear in the same cycle
		// Interrupt line in the same cycle as status
		next_s.int_sts = (s.int_sts & ~isc) | iset;
		next_s.irq = |(next_s.int_sts & s.int_en);

		// Registered copies of the port drive levels
		// One cycle behind the register bits
		next_s.en[0]   = port_sts[0][uhd_pkg::PRT_EN];
		next_s.en[1]   = port_sts[1][uhd_pkg::PRT_EN];
		next_s.susp[0] = port_sts[0][uhd_pkg::PRT_SUSP];
		next_s.susp[1] = port_sts[1][uhd_pkg::PRT_SUSP];
		next_s.rst[0]  = port_sts[0][uhd_pkg::PRT_RST];
		next_s.rst[1]  = port_sts[1][uhd_pkg::PRT_RST];
	end

	// State register, frame timer loaded at reset
	// Reset branch holds constants only
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s <= '0;
			s.defer <= uhd_pkg::DEFER_IDLE;
			s.frame <= 18'(FRAME_CYC - 1);
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	// No logic between flip-flop and pin
	assign rdata_out        = s.rdata;
	assign link_wr_out      = s.link_wr;
	assign link_addr_out    = s.link_addr;
	assign link_data_out    = s.link_data;
	assign done_wr_out      = s.done_wr;
	assign done_data_out    = s.done_data;
	assign port_power_out   = s.power;
	assign port_enable_out  = s.en;
	assign port_suspend_out = s.susp;
	assign port_reset_out   = s.rst;
	assign wake_out         = s.wake;
	assign irq_out          = s.irq;
endmodule // uhd_root_hub
`default_nettype wire

//--- verif/uhd_dev_model.sv
// Purpose: Two downstream devices seen at the root hub pins
// Assumes: Bench commands attach and speed per port
// Notes:   Speed pull-up only shows while attached
`timescale 1ns/1ps
`default_nettype none
module uhd_dev_model (
	input  wire logic       clk_in,
	input  wire logic [1:0] attach_in,
	input  wire logic [1:0] slow_in,
	output logic      [1:0] connect_out,
	output logic      [1:0] low_speed_out
);
	// Pins idle detached at time zero
	initial begin
		connect_out = 2'h0;
		low_speed_out = 2'h0;
	end
	// Detached device drives no speed pull-up
	always @(posedge clk_in) begin
		connect_out <= attach_in;
		low_speed_out <= attach_in & slow_in;
	end
endmodule // uhd_dev_model
`default_nettype wire

//--- verif/uhd_root_hub_chk.sv
// Purpose: Port-level checks of the root hub block
// Assumes: Bound to every root hub instance
// Notes:   Bus reset length allowed one cycle either way
`timescale 1ns/1ps
`default_nettype none
module uhd_root_hub_chk #(
	parameter int PRST_CYC = 8
) (
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        td_retire_in,
	input wire logic [27:0] td_addr_in,
	input wire logic        link_wr_out,
	input wire logic [31:0] link_addr_out,
	input wire logic [31:0] link_data_out,
	input wire logic        done_wr_out,
	input wire logic [31:0] done_data_out,
	input wire logic        port_power_out,
	input wire logic [1:0]  port_reset_out
);
	localparam int RST_LO = PRST_CYC - 1;
	localparam int RST_HI = PRST_CYC + 1;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic        wd_held;
	logic [31:0] rst_len;
	wire logic   hub_wr = wr_in && (addr_in == uhd_pkg::OFF_HUB);
	// Copy of the write-back flag and bus reset length count
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wd_held <= 1'b0;
			rst_len <= 32'h0;
		end else begin
			if (wr_in && addr_in == uhd_pkg::OFF_INT_ST && wdata_in[uhd_pkg::INT_WD])
				wd_held <= 1'b0;
			else if (done_wr_out)
				wd_held <= 1'b1;
			rst_len <= port_reset_out[0] ? rst_len + 32'h1 : 32'h0;
		end
	end
	// Two link writes in a row with no write-back between
	sequence s_link_pair;
		link_wr_out && $past(link_wr_out) && !done_wr_out;
	endsequence
	a_link_follows: assert property (
		td_retire_in |=> link_wr_out && link_addr_out == {$past(td_addr_in), 4'h0})
		else $error("link write missing after retire");
	a_lifo_order: assert property (
		s_link_pair |-> link_data_out == $past(link_addr_out))
		else $error("queue not linked newest first");
	a_done_single: assert property (
		done_wr_out |-> !wd_held)
		else $error("done pointer rewritten before flag cleared");
	a_done_shape: assert property (
		done_wr_out |-> done_data_out[3:1] == 3'h0)
		else $error("done pointer low bits wrong");
	a_desc_fixed: assert property (
		rd_in && addr_in == uhd_pkg::OFF_DESC_A |=> rdata_out == uhd_pkg::DESC_A_VAL)
		else $error("descriptor value wrong");
	a_power_off: assert property (
		hub_wr && wdata_in[uhd_pkg::HUB_PWR_OFF] && !wdata_in[uhd_pkg::HUB_PWR_ON] |-> ##[1:2] !port_power_out)
		else $error("power stayed on");
	a_power_on: assert property (
		hub_wr && wdata_in[uhd_pkg::HUB_PWR_ON] && !wdata_in[uhd_pkg::HUB_PWR_OFF] |-> ##[1:2] port_power_out)
		else $error("power stayed off");
	a_reset_len: assert property (
		$fell(port_reset_out[0]) |-> rst_len >= RST_LO && rst_len <= RST_HI)
		else $error("bus reset length wrong");
endmodule // uhd_root_hub_chk
bind uhd_root_hub uhd_root_hub_chk #(.PRST_CYC(PRST_CYC)) uhd_root_hub_chk_inst (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .td_retire_in(td_retire_in),
	.td_addr_in(td_addr_in), .link_wr_out(link_wr_out), .link_addr_out(link_addr_out),
	.link_data_out(link_data_out), .done_wr_out(done_wr_out), .done_data_out(done_data_out),
	.port_power_out(port_power_out), .port_reset_out(port_reset_out));
`default_nettype wire

//--- verif/usb_host_root_hub_done_queue_test.sv
// Purpose: Self-checking bench for the root hub block
// Assumes: Short frame and port reset counts
// Notes:   Reads and write-backs compared from queues
`timescale 1ns/1ps
`default_nettype none
module usb_host_root_hub_done_queue_test;
	localparam int FC = 50;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] PM = 32'h00170317;
	localparam logic [31:0] HM = 32'h00028001;
	typedef struct packed {logic [31:0] v; logic [31:0] m;} uhd_exp_s;
	logic clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0;
	logic overcurrent_in = 1'b0, td_retire_in = 1'b0;
	logic [7:0] addr_in = 8'h0;
	logic [31:0] wdata_in = 32'h0, seed = 32'hE8F8, rdata_out, link_addr_out, link_data_out, done_data_out;
	logic [27:0] td_addr_in = 28'h0;
	logic [27:0] ta [0:3];
	logic [2:0] td_delay_in = 3'h0;
	logic [1:0] attach = 2'h0, slow = 2'h0, connect_in, low_speed_in;
	logic [1:0] port_enable_out, port_suspend_out, port_reset_out;
	logic link_wr_out, done_wr_out, port_power_out, wake_out, irq_out;
	int fails = 0, total_checks = 0, i;
	uhd_exp_s rq[$], x;
	logic [31:0] dq[$];
	always #25 clk_in = ~clk_in;
	uhd_root_hub #(.FRAME_CYC(FC), .PRST_CYC(8)) uhd_root_hub_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.connect_in(connect_in), .low_speed_in(low_speed_in), .overcurrent_in(overcurrent_in),
		.td_retire_in(td_retire_in), .td_addr_in(td_addr_in), .td_delay_in(td_delay_in),
		.link_wr_out(link_wr_out), .link_addr_out(link_addr_out), .link_data_out(link_data_out),
		.done_wr_out(done_wr_out), .done_data_out(done_data_out), .port_power_out(port_power_out),
		.port_enable_out(port_enable_out), .port_suspend_out(port_suspend_out),
		.port_reset_out(port_reset_out), .wake_out(wake_out), .irq_out(irq_out));
	uhd_dev_model uhd_dev_model_inst (.clk_in(clk_in), .attach_in(attach), .slow_in(slow),
		.connect_out(connect_in), .low_speed_out(low_speed_in));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
		total_checks++;
		if (((e ^ g) & m) !== 32'h0) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		rq.push_back('{e, m});
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask
	// Bounded wait for a write-back (0) or a wake pulse (1)
	task automatic wt(input int sel, input int n);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge clk_in);
			if ((sel == 0 && done_wr_out === 1'b1) || (sel == 1 && wake_out === 1'b1))
				return;
		end
		fails++;
		$display("CHECK FAILED wait %0d expected 1 seen 0", sel);
		report_and_stop();
	endtask
	// Result watcher: read data one cycle after the strobe, pointer writes
	always @(posedge clk_in) begin
		if (rd_q) begin
			x = rq.pop_front();
			cmp("rdata", x.v, rdata_out, x.m);
		end
		if (done_wr_out === 1'b1) begin
			if (dq.size() == 0)
				cmp("done_wr", 32'h0, 32'h1, 32'h1);
			else
				cmp("done_ptr", dq.pop_front(), done_data_out, ALL);
		end
		rd_q <= rd_in;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd(uhd_pkg::OFF_DESC_A, uhd_pkg::DESC_A_VAL, ALL);
		wr(uhd_pkg::OFF_DESC_B, ALL);
		rd(uhd_pkg::OFF_DESC_B, uhd_pkg::DESC_B_VAL, ALL);
		rd(8'h24, 32'h0, ALL);
		$display("test descriptors ended");
		wr(uhd_pkg::OFF_HUB, 32'h00010000);
		attach <= 2'h3;
		slow <= 2'h2;
		repeat (6) @(posedge clk_in);
		rd(uhd_pkg::OFF_PORT0, 32'h00010101, PM);
		rd(uhd_pkg::OFF_PORT1, 32'h00010301, PM);
		wr(uhd_pkg::OFF_INT_EN, 32'h40);
		repeat (2) @(posedge clk_in);
		cmp("irq", 32'h1, {31'h0, irq_out}, 32'h1);
		wr(uhd_pkg::OFF_PORT0, 32'h00170000);
		wr(uhd_pkg::OFF_PORT0, 32'h0);
		rd(uhd_pkg::OFF_PORT0, 32'h00000101, PM);
		wr(uhd_pkg::OFF_PORT0, 32'h2);
		rd(uhd_pkg::OFF_PORT0, 32'h00020103, PM);
		cmp("enable", 32'h1, {31'h0, port_enable_out[0]}, 32'h1);
		wr(uhd_pkg::OFF_PORT0, 32'h4);
		rd(uhd_pkg::OFF_PORT0, 32'h00060107, PM);
		cmp("suspend", 32'h1, {31'h0, port_suspend_out[0]}, 32'h1);
		wr(uhd_pkg::OFF_PORT0, 32'h8);
		rd(uhd_pkg::OFF_PORT0, 32'h00060103, PM);
		wr(uhd_pkg::OFF_PORT0, 32'h1);
		rd(uhd_pkg::OFF_PORT0, 32'h00060101, PM);
		wr(uhd_pkg::OFF_PORT0, 32'h00170000);
		wr(uhd_pkg::OFF_PORT0, 32'h10);
		rd(uhd_pkg::OFF_PORT0, 32'h00000111, PM);
		cmp("reset", 32'h1, {31'h0, port_reset_out[0]}, 32'h1);
		repeat (12) @(posedge clk_in);
		rd(uhd_pkg::OFF_PORT0, 32'h00120103, PM);
		$display("test port commands ended");
		wr(uhd_pkg::OFF_HUB, 32'h00008000);
		rd(uhd_pkg::OFF_HUB, 32'h00008000, HM);
		attach <= 2'h1;
		wt(1, 10);
		wr(uhd_pkg::OFF_HUB, 32'h80000000);
		rd(uhd_pkg::OFF_HUB, 32'h0, HM);
		overcurrent_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		rd(uhd_pkg::OFF_HUB, 32'h00020001, HM);
		wr(uhd_pkg::OFF_HUB, 32'h00020000);
		rd(uhd_pkg::OFF_HUB, 32'h1, HM);
		overcurrent_in <= 1'b0;
		wr(uhd_pkg::OFF_HUB, 32'h1);
		rd(uhd_pkg::OFF_PORT0, 32'h0, 32'h103);
		rd(uhd_pkg::OFF_PORT1, 32'h0, 32'h100);
		$display("test hub ended");
		wr(uhd_pkg::OFF_INT_ST, ALL);
		wr(uhd_pkg::OFF_CMD, 32'h8);
		rd(uhd_pkg::OFF_INT_ST, 32'h40000000, 32'h40000000);
		wr(uhd_pkg::OFF_INT_EN, 32'h2);
		wr(uhd_pkg::OFF_INT_ST, ALL);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			ta[i] = seed[27:0] | 28'h1;
		end
		// Three retires back to back, first holds the write-back off
		for (i = 0; i < 3; i++) begin
			@(posedge clk_in);
			td_retire_in <= 1'b1;
			td_addr_in <= ta[i];
			td_delay_in <= (i == 0) ? 3'h2 : 3'h7;
		end
		@(posedge clk_in);
		td_retire_in <= 1'b0;
		rd(uhd_pkg::OFF_DONE, {ta[2], 4'h0}, ALL);
		dq.push_back({ta[2], 4'h0});
		wt(0, 4 * FC);
		@(posedge clk_in);
		td_retire_in <= 1'b1;
		td_addr_in <= ta[3];
		td_delay_in <= 3'h0;
		@(posedge clk_in);
		td_retire_in <= 1'b0;
		repeat (3 * FC) @(posedge clk_in);
		wr(uhd_pkg::OFF_INT_EN, 32'h40000002);
		wr(uhd_pkg::OFF_CMD, 32'h8);
		dq.push_back({ta[3], 4'h1});
		wr(uhd_pkg::OFF_INT_ST, 32'h2);
		wt(0, 2 * FC);
		rd(uhd_pkg::OFF_DONE, 32'h0, ALL);
		$display("test done queue ended");
		report_and_stop();
	end
endmodule // usb_host_root_hub_done_queue_test
`default_nettype wire
